//--- logic/rx_recovery.sv
// Purpose: receive side of an async NRZ serial port with APB register access
// Assumes: rxd synchronous to pclk; APB slave with zero wait states
// Notes: all state lives in one struct, one comb and one flop process
`timescale 1ns/100ps
module rx_recovery
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input rx_recovery_pkg::apb_req_t apb_req,
    output rx_recovery_pkg::apb_rsp_t apb_rsp,
    // serial line and interrupt
    input wire logic rxd,
    output logic irq
);
    import rx_recovery_pkg::*;

    rx_regs_t s_r;
    rx_regs_t s_nxt;

    logic tick;
    logic [4:0] pos;
    logic [2:0] trio;
    logic maj;
    logic setup;
    logic access;
    logic addr_ok;
    logic [3:0] nbits;
    logic late_edge;
    logic evt_hit;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    // true when the three samples are not unanimous
    function automatic logic disagree(input logic [2:0] v);
        disagree = (v != 3'h0) && (v != 3'h7);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // true at the three sample positions of a verify or data window
    function automatic logic at_sample(input logic [4:0] p, input logic [4:0] a,
        input logic [4:0] b, input logic [4:0] c);
        at_sample = (p == a) || (p == b) || (p == c);
    endfunction

    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign trio = {s_r.smp[1:0], rxd};
    assign maj = majority(trio);
    // nine-bit mode adds one data bit before the stop bit
    assign nbits = s_r.ctrl[CTRL_NINE] ? BITS_NINE : BITS_EIGHT;
    // position of the sample taken at this tick
    assign pos = s_r.rt + 5'h01;
    // greater-or-equal so a divisor lowered below the running count cannot
    // stall the divider for a whole wrap of the counter
    assign tick = (s_r.div_cnt >= s_r.baud);
    // one-to-zero step early in a bit that follows a one: the sender runs late
    assign late_edge = s_r.prev_bit & s_r.last_smp & ~rxd & (pos <= RT_RESYNC_MAX);
    // events reach the interrupt line only through the mask
    assign evt_hit = |(s_r.evt & s_r.mask);

    // unmapped words answer with an error; writes to read-only words are dropped
    always_comb
    begin
        addr_ok = 1'b0;
        if (hit(apb_req.paddr, OFF_DATA))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_STAT1))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_STAT2))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_CTRL))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_BAUD))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_EVT))
            addr_ok = 1'b1;
        else if (hit(apb_req.paddr, OFF_MASK))
            addr_ok = 1'b1;
    end

    always_comb
    begin
        s_nxt = s_r;

        // register bus: clears first so hardware sets below win
        if (setup)
        begin
            // latched in setup so the word stands through the access phase
            s_nxt.rdata = 32'h0;
            if (hit(apb_req.paddr, OFF_DATA))
                s_nxt.rdata[7:0] = s_r.data;
            else if (hit(apb_req.paddr, OFF_STAT1))
            begin
                s_nxt.rdata[ST1_FULL] = s_r.full;
                s_nxt.rdata[ST1_FE] = s_r.fe;
                s_nxt.rdata[ST1_NOISE] = s_r.nf;
                s_nxt.rdata[ST1_NINTH] = s_r.ninth;
            end
            else if (hit(apb_req.paddr, OFF_STAT2))
            begin
                s_nxt.rdata[ST2_RPF] = s_r.reception_active_flag;
                s_nxt.rdata[ST2_BKF] = s_r.break_flag;
            end
            else if (hit(apb_req.paddr, OFF_CTRL))
                s_nxt.rdata[2:0] = s_r.ctrl;
            else if (hit(apb_req.paddr, OFF_BAUD))
                s_nxt.rdata[15:0] = s_r.baud;
            else if (hit(apb_req.paddr, OFF_EVT))
                s_nxt.rdata[EVT_W-1:0] = s_r.evt;
            else if (hit(apb_req.paddr, OFF_MASK))
                s_nxt.rdata[EVT_W-1:0] = s_r.mask;
        end

        if (access && !apb_req.pwrite)
        begin
            if (hit(apb_req.paddr, OFF_STAT2) && s_r.break_flag)
                s_nxt.bkf_seen = 1'b1;
            else if (hit(apb_req.paddr, OFF_DATA))
            begin
                // reading the buffer acknowledges the character and its errors
                s_nxt.full = 1'b0;
                s_nxt.fe = 1'b0;
                s_nxt.nf = 1'b0;
                s_nxt.bkf_seen = 1'b0;
                if (s_r.bkf_seen)
                    s_nxt.break_flag = 1'b0;
            end
        end

        if (access && apb_req.pwrite)
        begin
            if (hit(apb_req.paddr, OFF_CTRL))
                s_nxt.ctrl = apb_req.pwdata[2:0];
            else if (hit(apb_req.paddr, OFF_BAUD))
                s_nxt.baud = apb_req.pwdata[15:0];
            else if (hit(apb_req.paddr, OFF_EVT))
                s_nxt.evt = s_r.evt & ~apb_req.pwdata[EVT_W-1:0];
            else if (hit(apb_req.paddr, OFF_MASK))
                s_nxt.mask = apb_req.pwdata[EVT_W-1:0];
        end

        // oversample tick divider
        s_nxt.div_cnt = tick ? 16'h0 : s_r.div_cnt + 16'h1;

        if (!s_r.ctrl[CTRL_RX_EN])
        begin
            // disabled receiver parks in search with the line history cleared
            s_nxt.fsm = ST_SEARCH;
            s_nxt.rt = 5'h0;
            s_nxt.hist = 3'h0;
            s_nxt.reception_active_flag = 1'b0;
            s_nxt.idle_cnt = 8'h0;
        end
        else if (tick)
        begin
            s_nxt.last_smp = rxd;
            if (rxd)
                s_nxt.break_armed = 1'b1;
            case (s_r.fsm)
                ST_SEARCH:
                begin
                    s_nxt.hist = {s_r.hist[1:0], rxd};
                    if (rxd)
                    begin
                        if (s_r.idle_cnt == IDLE_TICKS)
                            s_nxt.reception_active_flag = 1'b0;
                        else
                            s_nxt.idle_cnt = s_r.idle_cnt + 8'h1;
                    end
                    else
                        s_nxt.idle_cnt = 8'h0;
                    if (s_r.hist == 3'h7 && !rxd)
                    begin
                        s_nxt.fsm = ST_START;
                        s_nxt.rt = RT_FIRST;
                        s_nxt.reception_active_flag = 1'b1;
                        s_nxt.smp = 3'h0;
                    end
                end
                ST_START:
                begin
                    s_nxt.rt = pos;
                    if (at_sample(pos, RT_V1, RT_V2, RT_V3))
                        s_nxt.smp = trio;
                    if (pos == RT_V3)
                    begin
                        if (majority(trio))
                        begin
                            // false start: drop it and demand three ones again
                            s_nxt.fsm = ST_SEARCH;
                            s_nxt.rt = 5'h0;
                            s_nxt.hist = 3'h0;
                            s_nxt.reception_active_flag = 1'b0;
                        end
                        else if (trio != 3'h0)
                            s_nxt.nf = 1'b1;
                    end
                    if (pos == RT_LAST)
                    begin
                        // bit timing restarts from the end of the start bit
                        s_nxt.fsm = ST_DATA;
                        s_nxt.rt = 5'h0;
                        s_nxt.bitn = 4'h0;
                        s_nxt.all_zero = 1'b1;
                        s_nxt.prev_bit = 1'b0;
                    end
                end
                ST_DATA:
                begin
                    s_nxt.rt = pos;
                    if (at_sample(pos, RT_D1, RT_D2, RT_D3))
                        s_nxt.smp = trio;
                    if (pos == RT_D3)
                    begin
                        s_nxt.shift = {maj, s_r.shift[8:1]};
                        s_nxt.prev_bit = maj;
                        if (maj)
                            s_nxt.all_zero = 1'b0;
                        if (disagree(trio))
                            s_nxt.nf = 1'b1;
                    end
                    // only a late edge is pulled back; an early edge would
                    // need a bit skip and is left to the sample window
                    if (late_edge)
                        s_nxt.rt = RT_FIRST;
                    else if (pos == RT_LAST)
                    begin
                        s_nxt.rt = 5'h0;
                        s_nxt.bitn = s_r.bitn + 4'h1;
                        if (s_r.bitn + 4'h1 == nbits)
                            s_nxt.fsm = ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    s_nxt.rt = pos;
                    if (at_sample(pos, RT_D1, RT_D2, RT_D3))
                        s_nxt.smp = trio;
                    if (pos == RT_D3)
                    begin
                        s_nxt.fsm = ST_SEARCH;
                        s_nxt.rt = 5'h0;
                        s_nxt.hist = 3'h0;
                        s_nxt.full = 1'b1;
                        s_nxt.evt[EVT_CHAR] = 1'b1;
                        if (disagree(trio))
                        begin
                            s_nxt.nf = 1'b1;
                            s_nxt.evt[EVT_NOISE] = 1'b1;
                        end
                        if (s_r.nf)
                            s_nxt.evt[EVT_NOISE] = 1'b1;
                        if (s_r.ctrl[CTRL_NINE])
                        begin
                            s_nxt.data = s_r.shift[7:0];
                            s_nxt.ninth = s_r.shift[8];
                        end
                        else
                        begin
                            // an eight-bit character carries no ninth bit
                            s_nxt.data = s_r.shift[8:1];
                            s_nxt.ninth = 1'b0;
                        end
                        if (!maj)
                        begin
                            s_nxt.fe = 1'b1;
                            s_nxt.evt[EVT_FRAME] = 1'b1;
                        end
                        if (!maj && s_r.all_zero)
                        begin
                            s_nxt.fe = 1'b1;
                            if (s_r.ctrl[CTRL_NINE])
                                s_nxt.ninth = 1'b0;
                            if (s_r.break_armed)
                            begin
                                s_nxt.break_flag = 1'b1;
                                s_nxt.bkf_seen = 1'b0;
                                // follows rxd on this tick: rearmed at once if rxd is already high
                                s_nxt.break_armed = rxd;
                            end
                        end
                    end
                end
                default:
                begin
                    s_nxt.fsm = ST_SEARCH;
                    s_nxt.rt = 5'h0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.fsm <= ST_SEARCH;
            s_r.ctrl <= CTRL_RST;
            s_r.baud <= BAUD_RST;
            s_r.mask <= MASK_RST;
            s_r.break_armed <= 1'b0;
            s_r.break_flag <= 1'b0;
        end
        else
            s_r <= s_nxt;
    end

    // break deliberately has no path to the interrupt
    assign irq = (s_r.full & s_r.ctrl[CTRL_IRQ_EN]) | evt_hit;
    assign apb_rsp.prdata = s_r.rdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access & ~addr_ok;

endmodule

//--- logic/rx_recovery_pkg.sv
// Purpose: shared constants and types for the serial receive data recovery block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes: offsets and control layout are local choices
package rx_recovery_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_STAT1 = 8'h04;
    localparam logic [7:0] OFF_STAT2 = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_BAUD = 8'h10;
    localparam logic [7:0] OFF_EVT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;

    // field positions
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_IRQ_EN = 1;
    localparam int CTRL_NINE = 2;
    localparam int ST1_FULL = 0;
    localparam int ST1_FE = 1;
    localparam int ST1_NOISE = 2;
    localparam int ST1_NINTH = 3;
    localparam int ST2_RPF = 0;
    localparam int ST2_BKF = 1;
    localparam int EVT_CHAR = 0;
    localparam int EVT_NOISE = 1;
    localparam int EVT_FRAME = 2;
    localparam int EVT_W = 3;

    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] BAUD_RST = 16'h0043;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

    // oversample positions within one bit period (16 ticks per bit)
    localparam logic [4:0] RT_FIRST = 5'h01;
    localparam logic [4:0] RT_V1 = 5'h03;
    localparam logic [4:0] RT_V2 = 5'h05;
    localparam logic [4:0] RT_V3 = 5'h07;
    localparam logic [4:0] RT_D1 = 5'h08;
    localparam logic [4:0] RT_D2 = 5'h09;
    localparam logic [4:0] RT_D3 = 5'h0a;
    localparam logic [4:0] RT_LAST = 5'h10;
    localparam logic [4:0] RT_RESYNC_MAX = 5'h06;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    // idle character: ten bit periods of ones
    localparam logic [7:0] IDLE_TICKS = 8'ha0;

    typedef enum logic [3:0]
    {
        ST_SEARCH = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } rx_state_t;

    typedef struct packed
    {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed
    {
        rx_state_t fsm;
        logic [15:0] div_cnt;
        logic [4:0] rt;
        logic [2:0] hist;
        logic [2:0] smp;
        logic [3:0] bitn;
        logic [8:0] shift;
        logic prev_bit;
        logic last_smp;
        logic all_zero;
        logic [7:0] idle_cnt;
        logic break_armed;
        logic bkf_seen;
        logic [7:0] data;
        logic ninth;
        logic full;
        logic fe;
        logic nf;
        logic break_flag;
        logic reception_active_flag;
        logic [2:0] ctrl;
        logic [15:0] baud;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic [31:0] rdata;
    } rx_regs_t;

endpackage

//--- testbench/async_tx_model.sv
// Purpose: remote async transmitter driving the serial line
// Assumes: bit period in pclk cycles given by BIT_CLKS
// Notes: glitch inverts the line for two cycles to fake noise
`timescale 1ns/100ps
module async_tx_model
#(
    parameter int BIT_CLKS = 32
)
(
    // clock
    input wire logic pclk,
    // serial line
    output logic rxd
);
    initial rxd = 1'b1;

    task automatic send(input logic [8:0] val, input int nb, input logic stp, input int gl);
        logic [10:0] fr;
        fr = '1;
        fr[0] = 1'b0;
        for (int i = 0; i < nb; i++)
            fr[i + 1] = val[i];
        fr[nb + 1] = stp;
        // three idle bits so the search sees ones first
        repeat (3 * BIT_CLKS) @(posedge pclk);
        for (int t = 0; t < (nb + 2) * BIT_CLKS; t++)
        begin
            @(posedge pclk);
            rxd <= fr[t / BIT_CLKS] ^ (t >= gl && t < gl + 2);
        end
        @(posedge pclk);
        rxd <= 1'b1;
    endtask

    task automatic false_start();
        repeat (3 * BIT_CLKS) @(posedge pclk);
        rxd <= 1'b0;
        repeat (4) @(posedge pclk);
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
endmodule

//--- testbench/rx_recovery_asserts.sv
// Purpose: port-level checks of the receive block
// Assumes: zero wait state APB slave
// Notes: internal flags are judged by the bench
`timescale 1ns/100ps
module rx_recovery_asserts
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus, line, interrupt
    input rx_recovery_pkg::apb_req_t apb_req,
    input rx_recovery_pkg::apb_rsp_t apb_rsp,
    input wire logic rxd,
    input wire logic irq
);
    import rx_recovery_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rdq;
    assign acc = apb_req.psel & apb_req.penable;
    assign rdq = acc & ~apb_req.pwrite;
    sequence setup_s;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence access_s;
        apb_req.psel && apb_req.penable;
    endsequence

    a_ready_const: assert property (access_s |-> apb_rsp.pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (acc && apb_req.paddr > OFF_MASK |->
        apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && apb_req.paddr <= OFF_MASK && apb_req.paddr[1:0] == 2'h0
        |-> !apb_rsp.pslverr) else $error("error on mapped register");
    a_err_access: assert property (apb_rsp.pslverr |-> acc)
        else $error("pslverr outside access");
    a_prdata_hold: assert property (setup_s ##1 access_s |=> $stable(apb_rsp.prdata))
        else $error("read data moved in access");
    a_data_width: assert property (rdq && apb_req.paddr == OFF_DATA |->
        apb_rsp.prdata[31:8] == 24'h0) else $error("data upper bits set");
    a_stat2_width: assert property (rdq && apb_req.paddr == OFF_STAT2 |->
        apb_rsp.prdata[31:2] == 30'h0) else $error("status two upper bits set");
    a_irq_fall: assert property ($fell(irq) |-> $past(acc))
        else $error("irq dropped without access");
endmodule

bind rx_recovery rx_recovery_asserts rx_recovery_asserts_i (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .rxd(rxd), .irq(irq));

//--- testbench/test_uart_receiver_data_recovery.sv
// Purpose: self-checking bench for the serial receive block
// Assumes: tick every baud+1 cycles, sixteen ticks per bit
// Notes: one task per scenario, APB driven on rising edges
`timescale 1ns/100ps
module test_uart_receiver_data_recovery;
    import rx_recovery_pkg::*;
    localparam int BAUD_DIV = 1;
    localparam int BIT_CLKS = 16 * (BAUD_DIV + 1);
    localparam logic [31:0] FULL = 32'h1 << ST1_FULL;
    localparam logic [31:0] EN = 32'h1 << CTRL_RX_EN;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic rxd;
    logic irq;
    logic last_err;
    logic [31:0] rd;
    int bad_count = 0;
    int checks_done = 0;

    always #4 pclk = ~pclk;

    rx_recovery rx_recovery_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rxd(rxd), .irq(irq));
    async_tx_model #(.BIT_CLKS(BIT_CLKS)) async_tx_model_i (.pclk(pclk), .rxd(rxd));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 20);
        // a stuck slave ends the run rather than hanging it
        if (apb_rsp.pready !== 1'b1)
        begin
            bad_count++;
            end_of_test();
        end
        rd = apb_rsp.prdata;
        last_err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk_word(rd, exp, "register read");
    endtask

    task automatic ichk(input logic exp);
        // let the edge's register updates land first
        @(negedge pclk);
        chk_word({31'h0, irq}, {31'h0, exp}, "irq level");
    endtask

    task automatic t_reset();
        rchk(OFF_CTRL, 32'h0);
        rchk(OFF_BAUD, 32'h0043);
        rchk(OFF_MASK, 32'h0);
        rchk(OFF_STAT1, 32'h0);
        rchk(OFF_STAT2, 32'h0);
        ichk(1'b0);
        rchk(8'h20, 32'h0);
        chk_word({31'h0, last_err}, 32'h1, "unmapped error");
    endtask

    task automatic t_char();
        xfer(OFF_BAUD, 1'b1, BAUD_DIV);
        xfer(OFF_CTRL, 1'b1, EN);
        xfer(OFF_MASK, 1'b1, 32'h1 << EVT_CHAR);
        fork
            async_tx_model_i.send(9'h0a5, 8, 1'b1, -10);
            begin
                repeat (4 * BIT_CLKS) @(posedge pclk);
                rchk(OFF_STAT2, 32'h1 << ST2_RPF);
            end
        join
        rchk(OFF_STAT1, FULL);
        ichk(1'b1);
        rchk(OFF_EVT, 32'h1 << EVT_CHAR);
        xfer(OFF_EVT, 1'b1, 32'h7);
        ichk(1'b0);
        xfer(OFF_CTRL, 1'b1, EN | (32'h1 << CTRL_IRQ_EN));
        ichk(1'b1);
        xfer(OFF_DATA, 1'b1, 32'hff);
        rchk(OFF_DATA, 32'ha5);
        ichk(1'b0);
        rchk(OFF_STAT1, 32'h0);
        repeat (12 * BIT_CLKS) @(posedge pclk);
        rchk(OFF_STAT2, 32'h0);
    endtask

    task automatic t_noise();
        async_tx_model_i.send(9'h03c, 8, 1'b1, BIT_CLKS + 16);
        rchk(OFF_STAT1, FULL | (32'h1 << ST1_NOISE));
        rchk(OFF_DATA, 32'h3c);
        rchk(OFF_EVT, 32'h3);
        xfer(OFF_EVT, 1'b1, 32'h7);
    endtask

    task automatic t_nine();
        xfer(OFF_CTRL, 1'b1, EN | (32'h1 << CTRL_NINE));
        async_tx_model_i.send(9'h1c3, 9, 1'b1, -10);
        rchk(OFF_STAT1, FULL | (32'h1 << ST1_NINTH));
        rchk(OFF_DATA, 32'hc3);
        xfer(OFF_EVT, 1'b1, 32'h7);
    endtask

    task automatic t_false();
        xfer(OFF_CTRL, 1'b1, EN);
        async_tx_model_i.false_start();
        rchk(OFF_STAT2, 32'h0);
        // ninth bit of the last nine-bit character still stands
        rchk(OFF_STAT1, 32'h1 << ST1_NINTH);
        async_tx_model_i.send(9'h081, 8, 1'b1, -10);
        rchk(OFF_DATA, 32'h81);
        xfer(OFF_EVT, 1'b1, 32'h7);
    endtask

    task automatic t_break();
        xfer(OFF_MASK, 1'b1, 32'h0);
        // nonzero data with a low stop bit is a framing error, not a break
        async_tx_model_i.send(9'h055, 8, 1'b0, -10);
        rchk(OFF_STAT1, FULL | (32'h1 << ST1_FE));
        rchk(OFF_STAT2, 32'h1 << ST2_RPF);
        rchk(OFF_EVT, 32'h5);
        rchk(OFF_DATA, 32'h55);
        xfer(OFF_EVT, 1'b1, 32'h7);
        async_tx_model_i.send(9'h000, 8, 1'b0, -10);
        repeat (12 * BIT_CLKS) @(posedge pclk);
        rchk(OFF_STAT1, FULL | (32'h1 << ST1_FE));
        ichk(1'b0);
        rchk(OFF_DATA, 32'h0);
        // full is gone while break stands: the enable must not see break
        xfer(OFF_CTRL, 1'b1, EN | (32'h1 << CTRL_IRQ_EN));
        ichk(1'b0);
        rchk(OFF_STAT2, 32'h1 << ST2_BKF);
        rchk(OFF_DATA, 32'h0);
        rchk(OFF_STAT2, 32'h0);
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_char();
        t_noise();
        t_nine();
        t_false();
        t_break();
        end_of_test();
    end
endmodule
